// >>> hw/ovf_pkg.sv
/*
  Constants, field layout and state type for the output overvoltage fault
  action controller. Assumes one 100 MHz clock and a decoded byte-command
  port fed by the PMBus slave engine.
*/
//
// Contract
// - Fault action byte is read and written as one byte at command 0x41.
// - Bits 7:6 choose the reaction to a detected output overvoltage.
// - Response 00 keeps converting with the output enabled.
// - Response 01 keeps running for the delay count times the time unit.
// - Response 01 with fault still present after delay follows the retry count.
// - Response 10 disables the output at once, then follows the retry count.
// - Response 11 holds output off while fault persists, resumes once gone.
// - Bits 5:3 give the number of restart attempts after a shutdown.
// - Retry count 000 makes no restart; output stays off until cleared.
// - Counts 1 to 6 allow that many restarts, then stay off until cleared.
// - Retry count 111 restarts without limit until off or another stop.
// - Start-to-start spacing of restarts is the delay count times the unit.
// - Fault clears by status clear, clear-all command, reset, or off-then-on.
// - Delay field counts delay time units for both delay uses; the code uses 1 shifted left by the field (1 to 128 units) as the count.
// - Length of one delay time unit comes from the time unit register.

package ovf_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Command codes
  localparam logic [7:0] CMD_FAULT_ACTION = 8'h41;
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions within the fault action byte
  localparam int RESP_MSB  = 7;
  localparam int RESP_LSB  = 6;
  localparam int RETRY_MSB = 5;
  localparam int RETRY_LSB = 3;
  localparam int DELAY_MSB = 2;
  localparam int DELAY_LSB = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Field encodings and reset value
  localparam logic [1:0] RESP_IGNORE   = 2'h0;
  localparam logic [1:0] RESP_CONTINUE = 2'h1;
  localparam logic [1:0] RESP_DISABLE  = 2'h2;
  localparam logic [1:0] RESP_HOLD_OFF = 2'h3;
  localparam logic [2:0] RETRY_NONE    = 3'h0;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;
  localparam logic [7:0] ACTION_RESET  = 8'h80;
  localparam logic [7:0] UNITS_ONE     = 8'h01;

  ////////////////////////////////////////////////////////////////////////////
  // Controller states
  typedef enum logic [2:0] {
    ST_RUN,
    ST_CONT_DELAY,
    ST_RETRY_WAIT,
    ST_ATTEMPT,
    ST_LATCHED,
    ST_HOLD_OFF
  } ovf_state_t;

endpackage

// >>> hw/ovf_config_port.sv
/*
  Fault action byte storage and byte-command decode. Assumes the PMBus
  engine presents one decoded command per cmd_strobe pulse.
*/
`timescale 1ns/1ps
`default_nettype none

module ovf_config_port (
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  wire logic       cmd_strobe,
  input  wire logic       cmd_write,
  input  wire logic [7:0] cmd_code,
  input  wire logic [7:0] cmd_wdata,
  output logic      [7:0] cmd_rdata,
  output logic            cmd_ack,
  output logic            cmd_nak,
  output logic      [7:0] action,
  output logic            clear_faults
);

  logic [7:0] action_reg;
  logic [7:0] rdata_reg;
  logic       ack_reg;
  logic       nak_reg;
  wire        hit_action;
  wire        hit_clear;
  wire        accepted;

  // Decode of the two commands this block answers
  assign hit_action   = cmd_strobe && (cmd_code == ovf_pkg::CMD_FAULT_ACTION);
  assign hit_clear    = cmd_strobe && cmd_write && (cmd_code == ovf_pkg::CMD_CLEAR_FAULTS);
  assign accepted     = hit_action || hit_clear;
  assign clear_faults = hit_clear;
  assign action       = action_reg;
  assign cmd_rdata    = rdata_reg;
  assign cmd_ack      = ack_reg;
  assign cmd_nak      = nak_reg;

  // Byte write and read-back of the fault action setting
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      action_reg <= ovf_pkg::ACTION_RESET;
      rdata_reg  <= 8'h00;
      ack_reg    <= 1'b0;
      nak_reg    <= 1'b0;
    end else begin
      if (hit_action && cmd_write)
        action_reg <= cmd_wdata;
      if (hit_action && !cmd_write)
        rdata_reg <= action_reg;
      ack_reg <= accepted;
      nak_reg <= cmd_strobe && !accepted;
    end
  end

  sequence seq_write_action;
    cmd_strobe && cmd_write && cmd_code == ovf_pkg::CMD_FAULT_ACTION;
  endsequence

  sequence seq_read_action;
    cmd_strobe && !cmd_write && cmd_code == ovf_pkg::CMD_FAULT_ACTION;
  endsequence

  // Written byte comes back on the next read
  AST_ACTION_READBACK: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    seq_write_action ##1 !cmd_strobe ##1 seq_read_action
      |=> cmd_ack && cmd_rdata == $past(cmd_wdata, 3))
    else $error("fault action byte read-back differs from the byte written");

endmodule // ovf_config_port

`default_nettype wire

// >>> hw/ovf_delay_timer.sv
/*
  Delay timer counting whole delay time units. Assumes unit_cycles is held
  steady by the time unit register logic; zero is taken as one cycle.
*/
`timescale 1ns/1ps
`default_nettype none

module ovf_delay_timer (
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        start,
  input  wire logic [7:0]  units,
  input  wire logic [15:0] unit_cycles,
  output logic             done
);

  logic [15:0] prescale_reg;
  logic [7:0]  remain_reg;
  wire  [15:0] unit_last;
  wire         unit_tick;
  wire         running;

  // Unit boundary as a one-cycle enable from the prescaler
  assign unit_last = (unit_cycles == 16'h0000) ? 16'h0000 : unit_cycles - 16'h0001;
  assign running   = (remain_reg != 8'h00);
  assign unit_tick = running && (prescale_reg == unit_last);
  assign done      = unit_tick && (remain_reg == ovf_pkg::UNITS_ONE);

  // Prescaler and unit down-counter, reloaded by start
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      prescale_reg <= 16'h0000;
      remain_reg   <= 8'h00;
    end else if (start) begin
      prescale_reg <= 16'h0000;
      remain_reg   <= units;
    end else if (running) begin
      prescale_reg <= unit_tick ? 16'h0000 : prescale_reg + 16'h0001;
      if (unit_tick)
        remain_reg <= remain_reg - 8'h01;
    end
  end

  // Two units of two cycles end exactly four cycles after start
  AST_TIMER_SPAN: assert property (
    @(posedge ref_clk) disable iff (sys_rst || start)
    $past(start) && $past(units) == 8'h02 && unit_cycles == 16'h0002
      |-> !done[*3] ##1 done)
    else $error("delay timer span differs from units times unit length");

endmodule // ovf_delay_timer

`default_nettype wire

// >>> hw/ovf_fault_response.sv
/*
  Output overvoltage fault response controller: gates the power stage
  enable, times continue and retry delays, counts restarts and latches the
  output off until the fault is cleared. Assumes ov_detected and
  on_command are synchronous to ref_clk, and that unit_cycles comes from
  the time unit register logic.
*/
`timescale 1ns/1ps
`default_nettype none

module ovf_fault_response (
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        cmd_strobe,
  input  wire logic        cmd_write,
  input  wire logic [7:0]  cmd_code,
  input  wire logic [7:0]  cmd_wdata,
  output logic      [7:0]  cmd_rdata,
  output logic             cmd_ack,
  output logic             cmd_nak,
  input  wire logic        ov_detected,
  input  wire logic        on_command,
  input  wire logic        status_clear,
  input  wire logic [15:0] unit_cycles,
  output logic             output_enable,
  output logic             fault_status,
  output logic             fault_latched,
  output logic      [2:0]  attempt_count
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  ovf_pkg::ovf_state_t state_reg;
  ovf_pkg::ovf_state_t state_next;
  logic [2:0]          attempts_reg;
  logic [2:0]          attempts_next;
  logic                enable_reg;
  logic                status_reg;
  logic                on_prev_reg;
  logic                timer_start;
  logic                shutdown_now;
  logic [7:0]          action;
  logic                clear_faults;
  logic                timer_done;
  wire  [1:0]          resp_field;
  wire  [2:0]          retry_field;
  wire  [2:0]          delay_field;
  wire  [7:0]          delay_units;
  wire                 on_edge;
  wire                 clear_any;
  wire                 exhausted;
  wire                 fault_run;
  wire                 enable_next;

  ////////////////////////////////////////////////////////////////////////////
  // Command port and delay timer
  ovf_config_port u_config (
    .ref_clk      (ref_clk),
    .sys_rst      (sys_rst),
    .cmd_strobe   (cmd_strobe),
    .cmd_write    (cmd_write),
    .cmd_code     (cmd_code),
    .cmd_wdata    (cmd_wdata),
    .cmd_rdata    (cmd_rdata),
    .cmd_ack      (cmd_ack),
    .cmd_nak      (cmd_nak),
    .action       (action),
    .clear_faults (clear_faults)
  );

  ovf_delay_timer u_timer (
    .ref_clk     (ref_clk),
    .sys_rst     (sys_rst),
    .start       (timer_start),
    .units       (delay_units),
    .unit_cycles (unit_cycles),
    .done        (timer_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Field decode and clear sources
  assign resp_field  = action[ovf_pkg::RESP_MSB:ovf_pkg::RESP_LSB];
  assign retry_field = action[ovf_pkg::RETRY_MSB:ovf_pkg::RETRY_LSB];
  assign delay_field = action[ovf_pkg::DELAY_MSB:ovf_pkg::DELAY_LSB];
  assign delay_units = ovf_pkg::UNITS_ONE << delay_field;
  assign on_edge     = on_command && !on_prev_reg;
  assign clear_any   = clear_faults || status_clear || on_edge;
  assign fault_run   = (state_reg == ovf_pkg::ST_RUN) && ov_detected && on_command;
  assign exhausted   = (retry_field != ovf_pkg::RETRY_FOREVER) &&
                       (attempts_reg >= retry_field);

  ////////////////////////////////////////////////////////////////////////////
  // Next state, timer starts and restart counting
  always_comb begin
    state_next    = state_reg;
    attempts_next = attempts_reg;
    timer_start   = 1'b0;
    shutdown_now  = 1'b0;
    case (state_reg)
      ovf_pkg::ST_RUN: begin
        if (fault_run) begin
          case (resp_field)
            ovf_pkg::RESP_IGNORE: state_next = ovf_pkg::ST_RUN;
            ovf_pkg::RESP_CONTINUE: begin
              timer_start = 1'b1;
              state_next  = ovf_pkg::ST_CONT_DELAY;
            end
            ovf_pkg::RESP_DISABLE: shutdown_now = 1'b1;
            default: state_next = ovf_pkg::ST_HOLD_OFF;
          endcase
        end
      end
      ovf_pkg::ST_CONT_DELAY: begin
        if (timer_done && ov_detected)
          shutdown_now = 1'b1;
        else if (timer_done)
          state_next = ovf_pkg::ST_RUN;
      end
      ovf_pkg::ST_RETRY_WAIT: begin
        if (timer_done) begin
          timer_start   = 1'b1;
          attempts_next = (attempts_reg == ovf_pkg::RETRY_FOREVER) ?
                          attempts_reg : attempts_reg + 3'h1;
          state_next    = ovf_pkg::ST_ATTEMPT;
        end
      end
      ovf_pkg::ST_ATTEMPT: begin
        if (ov_detected && exhausted)
          state_next = ovf_pkg::ST_LATCHED;
        else if (ov_detected) begin
          timer_start = timer_done;
          state_next  = ovf_pkg::ST_RETRY_WAIT;
        end else if (timer_done)
          state_next = ovf_pkg::ST_RUN;
      end
      ovf_pkg::ST_LATCHED: state_next = ovf_pkg::ST_LATCHED;
      ovf_pkg::ST_HOLD_OFF: begin
        if (!ov_detected)
          state_next = ovf_pkg::ST_RUN;
      end
      default: state_next = ovf_pkg::ST_RUN;
    endcase
    // Shutdown: latch off with no retries, else wait one delay first
    if (shutdown_now) begin
      attempts_next = 3'h0;
      if (retry_field == ovf_pkg::RETRY_NONE)
        state_next = ovf_pkg::ST_LATCHED;
      else begin
        timer_start = 1'b1;
        state_next  = ovf_pkg::ST_RETRY_WAIT;
      end
    end
    // Off command or any fault clear ends the fault sequence
    if ((state_reg != ovf_pkg::ST_RUN) && (!on_command || clear_any)) begin
      state_next    = ovf_pkg::ST_RUN;
      timer_start   = 1'b0;
      attempts_next = 3'h0;
    end
  end

  // Output is on only in states that keep converting
  assign enable_next = on_command && ((state_next == ovf_pkg::ST_RUN) ||
                                      (state_next == ovf_pkg::ST_CONT_DELAY) ||
                                      (state_next == ovf_pkg::ST_ATTEMPT));

  ////////////////////////////////////////////////////////////////////////////
  // State registers
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg    <= ovf_pkg::ST_RUN;
      attempts_reg <= 3'h0;
      enable_reg   <= 1'b0;
      on_prev_reg  <= 1'b1; // No false on edge right after reset
    end else begin
      state_reg    <= state_next;
      attempts_reg <= attempts_next;
      enable_reg   <= enable_next;
      on_prev_reg  <= on_command;
    end
  end

  // Sticky fault status; a new detection wins over a clear
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst)
      status_reg <= 1'b0;
    else if (ov_detected)
      status_reg <= 1'b1;
    else if (clear_any)
      status_reg <= 1'b0;
  end

  assign output_enable = enable_reg;
  assign fault_status  = status_reg;
  assign fault_latched = (state_reg == ovf_pkg::ST_LATCHED);
  assign attempt_count = attempts_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  AST_IGNORE_KEEPS_ON: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    fault_run && resp_field == ovf_pkg::RESP_IGNORE |=> output_enable)
    else $error("ignore response dropped the output");

  AST_DISABLE_AT_ONCE: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    fault_run && resp_field == ovf_pkg::RESP_DISABLE |=> !output_enable)
    else $error("disable response did not drop the output at once");

  AST_CONT_STAYS_ON: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    fault_run && resp_field == ovf_pkg::RESP_CONTINUE
      |=> output_enable && state_reg == ovf_pkg::ST_CONT_DELAY)
    else $error("continue response did not keep running");

  AST_CONT_THEN_RETRY: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    state_reg == ovf_pkg::ST_CONT_DELAY && timer_done && ov_detected && on_command &&
      !clear_any && retry_field != ovf_pkg::RETRY_NONE
      |=> state_reg == ovf_pkg::ST_RETRY_WAIT && !output_enable)
    else $error("fault after continue delay did not start retries");

  AST_HOLD_WHILE_FAULT: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    state_reg == ovf_pkg::ST_HOLD_OFF && ov_detected && !clear_any
      |=> !output_enable ##1 (ov_detected || output_enable || !on_command || state_reg != ovf_pkg::ST_RUN))
    else $error("hold-off response enabled output during fault");

  AST_NO_RETRY_LATCH: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    shutdown_now && retry_field == ovf_pkg::RETRY_NONE && on_command && !clear_any
      |=> fault_latched && !output_enable)
    else $error("zero retry count did not latch the output off");

  AST_LATCHED_STAYS_OFF: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    fault_latched && on_command && !clear_any |=> fault_latched && !output_enable)
    else $error("latched fault left its state without a clear");

  AST_EXHAUST_LATCH: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    state_reg == ovf_pkg::ST_ATTEMPT && ov_detected && exhausted && on_command && !clear_any
      |=> fault_latched)
    else $error("last failed restart did not latch off");

  AST_FOREVER_RETRY: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    state_reg == ovf_pkg::ST_ATTEMPT && ov_detected && on_command && !clear_any &&
      retry_field == ovf_pkg::RETRY_FOREVER |=> state_reg == ovf_pkg::ST_RETRY_WAIT)
    else $error("continuous retry stopped retrying");

  AST_SET_WINS: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    ov_detected |=> fault_status)
    else $error("fault detection lost against a clear");

  AST_CLEAR_STATUS: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    clear_any && !ov_detected |=> !fault_status)
    else $error("clear did not remove the fault status");

  // Restart steps: delay ends, attempt runs, a failed attempt turns off
  sequence seq_retry_due;
    state_reg == ovf_pkg::ST_RETRY_WAIT && timer_done && on_command && !clear_any;
  endsequence

  sequence seq_attempt_live;
    state_reg == ovf_pkg::ST_ATTEMPT && output_enable;
  endsequence

  sequence seq_attempt_failed;
    state_reg == ovf_pkg::ST_ATTEMPT && ov_detected && !exhausted && on_command && !clear_any;
  endsequence

  AST_RETRY_ENABLES: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    seq_retry_due |=> seq_attempt_live)
    else $error("retry delay ended without a restart attempt");

  AST_ATTEMPT_COUNTED: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    seq_retry_due |=> attempt_count == $past(attempt_count) + 3'h1 ||
      $past(attempt_count) == ovf_pkg::RETRY_FOREVER)
    else $error("restart attempt was not counted");

  AST_FAILED_ATTEMPT_OFF: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    seq_attempt_failed |=> state_reg == ovf_pkg::ST_RETRY_WAIT && !output_enable)
    else $error("failed restart attempt left the output on");

  AST_HOLD_RESUMES: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    state_reg == ovf_pkg::ST_HOLD_OFF && !ov_detected && on_command
      |=> output_enable && state_reg == ovf_pkg::ST_RUN)
    else $error("hold-off response did not resume after the fault went");

  AST_CLEAR_RESTARTS: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    state_reg != ovf_pkg::ST_RUN && clear_any && on_command
      |=> state_reg == ovf_pkg::ST_RUN && output_enable)
    else $error("fault clear did not return the output to service");

  AST_OFF_COMMAND: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    !on_command |=> !output_enable && state_reg == ovf_pkg::ST_RUN)
    else $error("off command did not stop the output");

endmodule // ovf_fault_response

`default_nettype wire

// >>> verification/ovf_host_model.sv
/*
  Host-side model of the byte-command port: issues one decoded command at a
  time and captures the answer. Assumes ref_clk is the design clock.
*/
`timescale 1ns/1ps
`default_nettype none

module ovf_host_model (
  input  wire logic       ref_clk,
  output logic            cmd_strobe,
  output logic            cmd_write,
  output logic      [7:0] cmd_code,
  output logic      [7:0] cmd_wdata,
  input  wire logic [7:0] cmd_rdata,
  input  wire logic       cmd_ack,
  input  wire logic       cmd_nak
);
  // Idle port at time zero
  initial begin
    cmd_strobe = 1'b0;
    cmd_write  = 1'b0;
    cmd_code   = 8'h00;
    cmd_wdata  = 8'h00;
  end

  // One-cycle strobe, answer taken one cycle later; clear-all is sent here too
  task automatic xfer(input logic wr, input logic [7:0] code, input logic [7:0] wd,
                      output logic ack, output logic nak, output logic [7:0] rd);
    @(posedge ref_clk);
    cmd_strobe <= 1'b1;
    cmd_write  <= wr;
    cmd_code   <= code;
    cmd_wdata  <= wd;
    @(posedge ref_clk);
    cmd_strobe <= 1'b0;
    cmd_code   <= ~code; // Released lines show a changed pattern
    cmd_wdata  <= ~wd;
    #1;
    ack = cmd_ack;
    nak = cmd_nak;
    rd  = cmd_rdata;
  endtask
endmodule // ovf_host_model

`default_nettype wire

// >>> verification/overvoltage_fault_response_test.sv
/*
  Self-checking bench for the overvoltage fault response controller.
  Assumes the host model drives the command port; the bench drives the
  fault flag, on request, status clear and unit length.
*/
`timescale 1ns/1ps
`default_nettype none

module overvoltage_fault_response_test;
  logic        ref_clk, sys_rst, ov_detected, on_command, status_clear;
  logic [15:0] unit_cycles;
  logic        cmd_strobe, cmd_write, cmd_ack, cmd_nak;
  logic        output_enable, fault_status, fault_latched;
  logic [7:0]  cmd_code, cmd_wdata, cmd_rdata, rd;
  logic [2:0]  attempt_count;
  int          fail_count, total_checks;

  ////////////////////////////////////////////////////////////////////////////
  ovf_fault_response u_ovf_fault_response (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .cmd_strobe(cmd_strobe),
    .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
    .cmd_rdata(cmd_rdata), .cmd_ack(cmd_ack), .cmd_nak(cmd_nak),
    .ov_detected(ov_detected), .on_command(on_command),
    .status_clear(status_clear), .unit_cycles(unit_cycles),
    .output_enable(output_enable), .fault_status(fault_status),
    .fault_latched(fault_latched), .attempt_count(attempt_count));

  ovf_host_model u_ovf_host_model (
    .ref_clk(ref_clk), .cmd_strobe(cmd_strobe), .cmd_write(cmd_write),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata),
    .cmd_ack(cmd_ack), .cmd_nak(cmd_nak));

  // 100 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared helpers
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // Command through the host model; ack or nak judged at once
  task automatic cmd(input logic w, input logic [7:0] code, input logic [7:0] wd,
                     input logic exp_ack);
    logic a, n;
    u_ovf_host_model.xfer(w, code, wd, a, n, rd);
    check("ack", a, exp_ack);
    check("nak", n, !exp_ack);
  endtask

  // Program the action byte, then raise the fault
  task automatic arm(input logic [7:0] action);
    cmd(1'b1, ovf_pkg::CMD_FAULT_ACTION, action, 1'b1);
    @(posedge ref_clk);
    ov_detected <= 1'b1;
  endtask

  // Drop the fault and clear the status bit
  task automatic recover;
    @(posedge ref_clk);
    ov_detected  <= 1'b0;
    status_clear <= 1'b1;
    @(posedge ref_clk);
    status_clear <= 1'b0;
    tick(3);
  endtask

  // Count enable rises; gap is the spacing of the first two
  task automatic count_rises(input int cycles, output int rises, output int gap);
    logic prev;
    int   last;
    rises = 0;
    gap   = 0;
    last  = 0;
    prev  = output_enable;
    for (int i = 0; i < cycles; i++) begin
      @(posedge ref_clk);
      #1;
      if (output_enable === 1'b1 && prev !== 1'b1) begin
        if (rises == 1) gap = i - last;
        rises++;
        last = i;
      end
      prev = output_enable;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic do_register;
    #1;
    check("rdata_rst", cmd_rdata, 8'h00);
    check("en_rst", output_enable, 8'h01);
    cmd(1'b0, 8'h41, 8'h00, 1'b1);
    check("action_rst", rd, 8'h80);
    cmd(1'b1, 8'h41, 8'h5A, 1'b1);
    cmd(1'b0, 8'h41, 8'h00, 1'b1);
    check("action_rw", rd, 8'h5A);
    cmd(1'b1, 8'h42, 8'h11, 1'b0);
    cmd(1'b0, 8'h03, 8'h00, 1'b0);
    cmd(1'b0, 8'h41, 8'h00, 1'b1);
    check("action_kept", rd, 8'h5A);
  endtask

  task automatic do_ignore;
    arm(8'h00);
    tick(6);
    #1;
    check("ign_en", output_enable, 8'h01);
    check("ign_status", fault_status, 8'h01);
    recover;
  endtask

  task automatic do_continue;
    unit_cycles <= 16'h0002;
    arm(8'h41);
    tick(3);
    #1;
    check("cont_en", output_enable, 8'h01);
    tick(7);
    #1;
    check("cont_off", output_enable, 8'h00);
    check("cont_latch", fault_latched, 8'h01);
    recover;
    arm(8'h41);
    @(posedge ref_clk);
    ov_detected <= 1'b0;
    tick(10);
    #1;
    check("cont_gone", output_enable, 8'h01);
    recover;
  endtask

  task automatic do_disable;
    arm(8'h80);
    tick(1);
    #1;
    check("dis_en", output_enable, 8'h00);
    @(posedge ref_clk);
    ov_detected <= 1'b0;
    tick(8);
    #1;
    check("dis_stay", output_enable, 8'h00);
    check("dis_latch", fault_latched, 8'h01);
    check("dis_cnt", attempt_count, 8'h00);
    @(posedge ref_clk);
    status_clear <= 1'b1;
    tick(1);
    status_clear <= 1'b0;
    tick(2);
    #1;
    check("dis_clr", output_enable, 8'h01);
  endtask

  task automatic do_retries;
    int rises, gap;
    @(posedge ref_clk);
    unit_cycles <= 16'h0002;
    for (int n = 1; n <= 3; n++) begin
      arm({2'b10, 3'(n), 3'h1});
      count_rises(40, rises, gap);
      check("ret_rises", 8'(rises), 8'(n));
      check("ret_cnt", attempt_count, 8'(n));
      check("ret_latch", fault_latched, 8'h01);
      if (n > 1) check("ret_gap", 8'(gap), 8'h04);
      @(posedge ref_clk);
      ov_detected <= 1'b0;
      cmd(1'b1, ovf_pkg::CMD_CLEAR_FAULTS, 8'h00, 1'b1);
      tick(2);
      #1;
      check("ret_clr", output_enable, 8'h01);
    end
  endtask

  task automatic do_forever;
    int rises, gap;
    arm(8'hB9);
    count_rises(60, rises, gap);
    check("fov_many", 8'(rises >= 8), 8'h01);
    check("fov_latch", fault_latched, 8'h00);
    @(posedge ref_clk);
    on_command <= 1'b0;
    tick(2);
    #1;
    check("fov_off", output_enable, 8'h00);
    @(posedge ref_clk);
    ov_detected <= 1'b0;
    tick(2);
    on_command <= 1'b1;
    tick(3);
    #1;
    check("fov_on", output_enable, 8'h01);
  endtask

  task automatic do_hold;
    arm(8'hC0);
    tick(1);
    #1;
    check("hold_en", output_enable, 8'h00);
    tick(5);
    #1;
    check("hold_stay", output_enable, 8'h00);
    @(posedge ref_clk);
    ov_detected <= 1'b0;
    tick(2);
    #1;
    check("hold_back", output_enable, 8'h01);
    check("hold_status", fault_status, 8'h01);
    recover;
  endtask

  task automatic do_midreset;
    arm(8'h80);
    tick(3);
    sys_rst <= 1'b1;
    tick(2);
    #1;
    check("rst_en", output_enable, 8'h00);
    check("rst_latch", fault_latched, 8'h00);
    check("rst_status", fault_status, 8'h00);
    @(posedge ref_clk);
    sys_rst     <= 1'b0;
    ov_detected <= 1'b0;
    tick(2);
    cmd(1'b0, 8'h41, 8'h00, 1'b1);
    check("rst_action", rd, 8'h80);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Watchdog against a hang
  initial begin
    #100000;
    fail_count++;
    summarize;
  end

  // Main sequence
  initial begin
    fail_count   = 0;
    total_checks = 0;
    sys_rst      = 1'b1;
    ov_detected  = 1'b0;
    on_command   = 1'b1;
    status_clear = 1'b0;
    unit_cycles  = 16'h0001;
    tick(5);
    sys_rst <= 1'b0;
    tick(2);
    do_register;
    do_ignore;
    do_continue;
    do_disable;
    do_retries;
    do_forever;
    do_hold;
    do_midreset;
    summarize;
  end
endmodule // overvoltage_fault_response_test

`default_nettype wire
